// ==== common/dlc_pkg.sv ====
package dlc_pkg;

    // Core clock and line timing.
    localparam int unsigned CLK_HZ = 10_000_000;
    localparam int unsigned CLK_MHZ = CLK_HZ / 1_000_000;
    localparam int unsigned CLK_PER_MS = CLK_HZ / 1_000;

    // The line rate is the core clock divided by eight, so 8 to 20 MHz gives 1.0 to 2.5 Mbps.
    localparam int unsigned CLK_PER_BIT = 8;
    localparam int unsigned PHASE_W = 3;
    localparam logic [2:0] PHASE_FIRST = 3'h0;
    localparam logic [2:0] PHASE_STEP = 3'h1;
    localparam logic [2:0] PHASE_LAST = 3'(CLK_PER_BIT - 1);

    // Transmit pulse width, a least time, so it rounds up to whole cycles.
    localparam int unsigned PULSE_NS = 100;
    localparam int unsigned PULSE_CYCLES_RAW = (PULSE_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned PULSE_CYCLES = (PULSE_CYCLES_RAW < 1) ? 1 : PULSE_CYCLES_RAW;
    localparam logic [2:0] PULSE_A_END = 3'(PULSE_CYCLES);
    localparam logic [2:0] PULSE_B_END = 3'(2 * PULSE_CYCLES);

    // Receive slot spacing at the top crystal rate and the tolerated arrival jitter.
    localparam int unsigned RX_SLOT_NS = 400;
    localparam int unsigned RX_TOL_NS = 100;
    localparam int unsigned RX_TOL_CYCLES_RAW = (RX_TOL_NS * CLK_MHZ) / 1000;
    localparam int unsigned RX_TOL_CYCLES = (RX_TOL_CYCLES_RAW < 1) ? 1 : RX_TOL_CYCLES_RAW;
    // A slot closes half a bit after its centre, so any pulse within half a bit is caught.
    localparam logic [2:0] RX_CLOSE_PHASE = 3'(CLK_PER_BIT / 2);
    // Consecutive zero bits counted before the next zero drops the receiver back to idle.
    localparam logic [4:0] RX_IDLE_LAST = 5'hf;
    localparam logic [4:0] RX_RUN_STEP = 5'h01;

    // LED one-shot intervals.
    localparam int unsigned TX_LED_US = 726;
    localparam int unsigned TX_LED_CYCLES = TX_LED_US * CLK_MHZ;
    localparam int unsigned HOST_LED_MS = 400;
    localparam int unsigned HOST_LED_CYCLES = HOST_LED_MS * CLK_PER_MS;

    // Register byte offsets on the Wishbone slave.
    localparam int unsigned ADR_W = 4;
    localparam logic [3:0] REG_CONFIG = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam logic [3:0] REG_MASK = 4'h8;
    localparam logic [3:0] REG_STATE = 4'hc;

    // Field positions.
    localparam int unsigned CFG_TXDIS = 0;
    localparam int unsigned EVT_W = 3;
    localparam int unsigned ST_RECONFIG = 0;
    localparam int unsigned ST_RX_ACT = 1;
    localparam int unsigned ST_TOKEN = 2;
    localparam int unsigned SS_OWN_RECONFIG = 0;
    localparam int unsigned SS_RX_ACTIVE = 1;
    localparam int unsigned SS_TX_BUSY = 2;
    localparam int unsigned SS_TX_LED = 3;
    localparam int unsigned SS_HOST_LED = 4;
    localparam int unsigned SS_W = 5;

    // Reset values.
    localparam logic CONFIG_RST = 1'b0;
    localparam logic [2:0] MASK_RST = 3'h0;

endpackage : dlc_pkg

// ==== logic/dlc_line_codec.sv ====
// Behaviour
// - Each sent one gives two separate 100 ns pulses, one per transmit output.
// - Each sent zero leaves both transmit outputs inactive for the whole bit.
// - Positive receive pulses are captured and turned into NRZ serial data.
// - Pulses at bit multiples, displaced up to 100 ns, still decode correctly.
// - A network reconfiguration raises the reconfiguration interrupt flag.
// - Own-reconfiguration flag goes high when this node caused the reconfiguration.
// - Receive-activity flag sets on each rising edge of recovered NRZ data.
// - Token-seen flag sets on any token except those this node sent.
// - Transmit LED stays on 726 us, restarted by each one bit sent while the transmitter is enabled.
// - Every host access keeps the bus-activity LED on for 400 ms.
// - Line bit rate is the crystal clock divided by eight.
module dlc_line_codec #(
    parameter int unsigned TX_LED_CYCLES = dlc_pkg::TX_LED_CYCLES,
    parameter int unsigned HOST_LED_CYCLES = dlc_pkg::HOST_LED_CYCLES
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Wishbone classic slave.
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [dlc_pkg::ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic irq_o,
    // Transmit bit stream from the protocol engine.
    input wire logic tx_valid_i,
    input wire logic tx_data_i,
    output logic tx_ready_o,
    // Media driver pins.
    output logic tx_pulse_a_n_o,
    output logic tx_pulse_b_n_o,
    input wire logic line_rx_pulse_in_i,
    // Recovered NRZ stream to the receiver.
    output logic rx_data_o,
    output logic rx_valid_o,
    output logic rx_active_o,
    // Protocol engine events.
    input wire logic reconfig_evt_i,
    input wire logic reconfig_by_self_i,
    input wire logic token_seen_i,
    input wire logic token_own_i,
    input wire logic host_access_i,
    output logic transmitter_disable_o,
    // LED pins.
    output logic tx_led_n_o,
    output logic host_access_led_n_o
);

    typedef enum logic [0:0] {
        TX_IDLE,
        TX_BIT
    } dlc_tx_state_t;

    typedef struct packed {
        logic [2:0] sync;
        logic rx_stable;
        logic [2:0] rx_phase;
        logic rx_seen;
        logic rx_active;
        logic [4:0] rx_zero_run;
        logic rx_last;
        logic rx_data;
        logic rx_valid;
        dlc_tx_state_t tx_state;
        logic [2:0] tx_phase;
        logic tx_one;
        logic pulse_a;
        logic pulse_b;
        logic transmitter_disable;
        logic [dlc_pkg::EVT_W-1:0] status;
        logic [dlc_pkg::EVT_W-1:0] mask;
        logic own_reconfig_flag;
        logic ack;
        logic [31:0] rdata;
    } dlc_state_t;

    dlc_state_t q;
    dlc_state_t d;

    logic tx_led_on;
    logic host_led_on;
    logic tx_take;
    logic tx_led_trig;
    logic host_trig;
    logic wb_req;
    logic rx_rise;
    logic rx_emit;
    logic rx_bit;
    logic [dlc_pkg::EVT_W-1:0] evt;
    logic [dlc_pkg::EVT_W-1:0] clr;
    logic [dlc_pkg::SS_W-1:0] state_word;

    // A new bit is accepted while idle or in the last cycle of the current bit.
    assign tx_ready_o = (q.tx_state == TX_IDLE) || (q.tx_phase == dlc_pkg::PHASE_LAST);
    assign tx_take = ce_i && tx_valid_i && tx_ready_o;
    assign wb_req = wb_cyc_i && wb_stb_i && !q.ack;

    // A receive edge counts only once the second and third stages agree on a high level.
    assign rx_rise = q.sync[1] && q.sync[2] && !q.rx_stable;
    assign rx_emit = q.rx_active && (q.rx_phase == dlc_pkg::RX_CLOSE_PHASE);
    assign rx_bit = q.rx_seen;

    always_comb begin
        state_word = '0;
        state_word[dlc_pkg::SS_OWN_RECONFIG] = q.own_reconfig_flag;
        state_word[dlc_pkg::SS_RX_ACTIVE] = q.rx_active;
        state_word[dlc_pkg::SS_TX_BUSY] = (q.tx_state == TX_BIT);
        state_word[dlc_pkg::SS_TX_LED] = tx_led_on;
        state_word[dlc_pkg::SS_HOST_LED] = host_led_on;
    end

    always_comb begin
        evt = '0;
        evt[dlc_pkg::ST_RECONFIG] = reconfig_evt_i;
        evt[dlc_pkg::ST_RX_ACT] = rx_emit && rx_bit && !q.rx_last;
        evt[dlc_pkg::ST_TOKEN] = token_seen_i && !token_own_i;
        clr = '0;
        if (wb_req && wb_we_i && wb_sel_i[0] && (wb_adr_i == dlc_pkg::REG_STATUS)) begin
            clr = wb_dat_i[dlc_pkg::EVT_W-1:0];
        end
    end

    always_comb begin
        d = q;
        tx_led_trig = 1'b0;
        host_trig = 1'b0;
        if (ce_i) begin
            // Receive synchroniser: stage zero feeds stage one only.
            d.sync = {q.sync[1], q.sync[0], line_rx_pulse_in_i};
            if (q.sync[1] == q.sync[2]) begin
                d.rx_stable = q.sync[2];
            end

            // Receive slot timing; the phase re-centres on every pulse so jitter never
            // accumulates across a run of zeros.
            d.rx_valid = 1'b0;
            if (q.rx_active) begin
                d.rx_phase = 3'(q.rx_phase + dlc_pkg::PHASE_STEP);
            end
            if (rx_emit) begin
                d.rx_data = rx_bit;
                d.rx_valid = 1'b1;
                d.rx_seen = 1'b0;
                d.rx_last = rx_bit;
                if (rx_bit) begin
                    d.rx_zero_run = '0;
                end else if (q.rx_zero_run == dlc_pkg::RX_IDLE_LAST) begin
                    d.rx_active = 1'b0;
                    d.rx_last = 1'b0;
                    d.rx_zero_run = '0;
                end else begin
                    d.rx_zero_run = 5'(q.rx_zero_run + dlc_pkg::RX_RUN_STEP);
                end
            end
            if (rx_rise) begin
                // Any pulse within half a bit of a slot centre lands in that slot.
                d.rx_phase = dlc_pkg::PHASE_FIRST;
                d.rx_seen = 1'b1;
                d.rx_active = 1'b1;
            end

            // Transmit bit timing.
            if (q.tx_state == TX_BIT) begin
                d.tx_phase = 3'(q.tx_phase + dlc_pkg::PHASE_STEP);
                if (q.tx_phase == dlc_pkg::PHASE_LAST) begin
                    d.tx_state = TX_IDLE;
                    d.tx_one = 1'b0;
                end
            end
            if (tx_take) begin
                d.tx_state = TX_BIT;
                d.tx_phase = dlc_pkg::PHASE_FIRST;
                // A disabled transmitter still paces bits but puts nothing on the line.
                d.tx_one = tx_data_i && !q.transmitter_disable;
                tx_led_trig = tx_data_i && !q.transmitter_disable;
            end
            // Pulse A covers the first pulse width, pulse B the next, so they never overlap.
            d.pulse_a = (d.tx_state == TX_BIT) && d.tx_one
                && (d.tx_phase < dlc_pkg::PULSE_A_END);
            d.pulse_b = (d.tx_state == TX_BIT) && d.tx_one
                && (d.tx_phase >= dlc_pkg::PULSE_A_END)
                && (d.tx_phase < dlc_pkg::PULSE_B_END);

            // Sticky flags: a set in the cycle of its clear wins.
            d.status = (q.status & ~clr) | evt;
            if (reconfig_evt_i) begin
                d.own_reconfig_flag = reconfig_by_self_i;
            end

            // Wishbone slave: one cycle to ack, registered read data.
            d.ack = wb_req;
            host_trig = wb_req || host_access_i;
            if (wb_req) begin
                if (wb_we_i && wb_sel_i[0]) begin
                    case (wb_adr_i)
                        dlc_pkg::REG_CONFIG: begin
                            d.transmitter_disable = wb_dat_i[dlc_pkg::CFG_TXDIS];
                        end
                        dlc_pkg::REG_MASK: begin
                            d.mask = wb_dat_i[dlc_pkg::EVT_W-1:0];
                        end
                        default: begin
                        end
                    endcase
                end
                case (wb_adr_i)
                    dlc_pkg::REG_CONFIG: begin
                        d.rdata = 32'(q.transmitter_disable);
                    end
                    dlc_pkg::REG_STATUS: begin
                        d.rdata = 32'(q.status);
                    end
                    dlc_pkg::REG_MASK: begin
                        d.rdata = 32'(q.mask);
                    end
                    dlc_pkg::REG_STATE: begin
                        d.rdata = 32'(state_word);
                    end
                    default: begin
                        d.rdata = 32'h0;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    dlc_oneshot #(
        .CYCLES(TX_LED_CYCLES)
    ) u_tx_led (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .trig_i(tx_led_trig),
        .active_o(tx_led_on)
    );

    dlc_oneshot #(
        .CYCLES(HOST_LED_CYCLES)
    ) u_host_led (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .trig_i(host_trig),
        .active_o(host_led_on)
    );

    assign tx_pulse_a_n_o = !q.pulse_a;
    assign tx_pulse_b_n_o = !q.pulse_b;
    assign rx_data_o = q.rx_data;
    assign rx_valid_o = q.rx_valid;
    assign rx_active_o = q.rx_active;
    assign transmitter_disable_o = q.transmitter_disable;
    assign tx_led_n_o = !tx_led_on;
    assign host_access_led_n_o = !host_led_on;
    assign wb_ack_o = q.ack;
    assign wb_dat_o = q.rdata;
    assign irq_o = |(q.status & q.mask);

endmodule : dlc_line_codec

// ==== logic/dlc_oneshot.sv ====
module dlc_oneshot #(
    parameter int unsigned CYCLES = 16
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic trig_i,
    output logic active_o
);

    typedef struct packed {
        logic [31:0] cnt;
        logic on;
    } dlc_shot_t;

    dlc_shot_t q;
    dlc_shot_t d;

    // A trigger reloads the full interval, so repeated triggers stretch the output.
    always_comb begin
        d = q;
        if (ce_i) begin
            if (trig_i) begin
                d.cnt = 32'(CYCLES - 1);
                d.on = 1'b1;
            end else if (q.cnt != 32'h0) begin
                d.cnt = q.cnt - 32'h1;
                d.on = 1'b1;
            end else begin
                d.on = 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign active_o = q.on;

endmodule : dlc_oneshot

// ==== sim/dlc_line_codec_monitor.sv ====
module dlc_line_codec_monitor #(
    parameter int unsigned TX_LED_CYCLES = 20,
    parameter int unsigned HOST_LED_CYCLES = 40
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic irq_o,
    input wire logic tx_valid_i,
    input wire logic tx_data_i,
    input wire logic tx_ready_o,
    input wire logic tx_pulse_a_n_o,
    input wire logic tx_pulse_b_n_o,
    input wire logic rx_valid_o,
    input wire logic rx_active_o,
    input wire logic host_access_i,
    input wire logic transmitter_disable_o,
    input wire logic tx_led_n_o,
    input wire logic host_access_led_n_o
);
    timeunit 1ns;
    timeprecision 1ns;
    int unsigned tx_age_q, hs_age_q;
    logic take, tx_trig, hs_trig;
    assign take = ce_i && tx_valid_i && tx_ready_o;
    assign tx_trig = take && tx_data_i && !transmitter_disable_o;
    assign hs_trig = ce_i && (host_access_i || (wb_cyc_i && wb_stb_i && !wb_ack_o));
    // Ages saturate so a long idle never wraps back into the lit window.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tx_age_q <= TX_LED_CYCLES;
            hs_age_q <= HOST_LED_CYCLES;
        end else if (ce_i) begin
            tx_age_q <= tx_trig ? 32'h0 : tx_age_q + 32'(tx_age_q < TX_LED_CYCLES);
            hs_age_q <= hs_trig ? 32'h0 : hs_age_q + 32'(hs_age_q < HOST_LED_CYCLES);
        end
    end
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    pulse_pair_a: assert property (tx_trig
        |=> !tx_pulse_a_n_o ##1 (tx_pulse_a_n_o && !tx_pulse_b_n_o) ##1 tx_pulse_b_n_o)
        else $error("transmit pulse pair wrong");
    no_overlap_a: assert property (tx_pulse_a_n_o || tx_pulse_b_n_o)
        else $error("transmit pulses overlap");
    zero_quiet_a: assert property (take && !(tx_data_i && !transmitter_disable_o)
        |=> (tx_pulse_a_n_o && tx_pulse_b_n_o)[*8])
        else $error("pulse during a quiet bit");
    bit_period_a: assert property (take |=> !tx_ready_o[*7] ##1 tx_ready_o)
        else $error("bit period not eight cycles");
    rx_strobe_a: assert property (rx_valid_o |=> !rx_valid_o)
        else $error("receive strobe too long");
    tx_led_time_a: assert property (tx_led_n_o == (tx_age_q >= TX_LED_CYCLES))
        else $error("transmit lamp timing wrong");
    host_led_time_a: assert property (
        host_access_led_n_o == (hs_age_q >= HOST_LED_CYCLES))
        else $error("host lamp timing wrong");
    reset_idle_a: assert property ($fell(rst_i) |-> tx_pulse_a_n_o && tx_pulse_b_n_o
        && tx_led_n_o && host_access_led_n_o && !irq_o && !rx_active_o && tx_ready_o)
        else $error("outputs not idle after reset");
endmodule : dlc_line_codec_monitor

bind dlc_line_codec dlc_line_codec_monitor #(
    .TX_LED_CYCLES(TX_LED_CYCLES), .HOST_LED_CYCLES(HOST_LED_CYCLES)) mon (
    .clk_i, .rst_i, .ce_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .irq_o, .tx_valid_i,
    .tx_data_i, .tx_ready_o, .tx_pulse_a_n_o, .tx_pulse_b_n_o, .rx_valid_o, .rx_active_o,
    .host_access_i, .transmitter_disable_o, .tx_led_n_o, .host_access_led_n_o);

// ==== sim/dlc_line_codec_test.sv ====
module dlc_line_codec_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0, rst = 1'b1, req = 1'b0, we = 1'b0, fire = 1'b0;
    logic txv = 1'b0, txd = 1'b0, rc = 1'b0, slf = 1'b0, tk = 1'b0, hst = 1'b0;
    logic [3:0] adr = 4'h0;
    logic [31:0] wdat = 32'h0, rdat, q;
    logic ack, irq, txr, pa, pb, line, rxd, rxv, rxa, txdis, tled, hled;
    int n_fail = 0, checked = 0, cyc_n = 0, na, nb;
    logic rxq[$];
    initial forever #50 clk = ~clk;
    dlc_line_codec #(.TX_LED_CYCLES(20), .HOST_LED_CYCLES(40)) dut (
        .clk_i(clk), .rst_i(rst), .ce_i(1'b1), .wb_cyc_i(req), .wb_stb_i(req),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .irq_o(irq), .tx_valid_i(txv), .tx_data_i(txd), .tx_ready_o(txr),
        .tx_pulse_a_n_o(pa), .tx_pulse_b_n_o(pb), .line_rx_pulse_in_i(line),
        .rx_data_o(rxd), .rx_valid_o(rxv), .rx_active_o(rxa), .reconfig_evt_i(rc),
        .reconfig_by_self_i(slf), .token_seen_i(tk), .token_own_i(slf),
        .host_access_i(hst), .transmitter_disable_o(txdis), .tx_led_n_o(tled),
        .host_access_led_n_o(hled));
    dlc_media_model media (.clk_i(clk), .fire_i(fire), .tx_pulse_a_n_i(pa),
        .tx_pulse_b_n_i(pb), .line_o(line), .n_a(na), .n_b(nb));
    always @(posedge clk) if (rxv === 1'b1) rxq.push_back(rxd);
    always @(posedge clk) begin
        cyc_n++;
        if (cyc_n == 5000) begin
            n_fail++;
            tally_and_finish();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        req <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clk);
        end while (ack !== 1'b1);
        q = rdat;
        req <= 1'b0;
        @(posedge clk);
    endtask : wb
    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        chk(q, e);
    endtask : rd
    task automatic send(input logic b);
        txv <= 1'b1;
        txd <= b;
        do begin
            @(posedge clk);
        end while (txr !== 1'b1);
    endtask : send
    task automatic evt(input logic [1:0] k, input logic s);
        rc <= k[0];
        tk <= k[1];
        slf <= s;
        hst <= 1'b1;
        @(posedge clk);
        rc <= 1'b0;
        tk <= 1'b0;
        hst <= 1'b0;
        @(posedge clk);
    endtask : evt
    task automatic t_regs();
        rd(4'h0, 32'h0);
        rd(4'h4, 32'h0);
        rd(4'h8, 32'h0);
        wb(1'b1, 4'h2, 32'hff);
        rd(4'h2, 32'h0);
        chk(32'(hled), 32'h0);
    endtask : t_regs
    task automatic t_tx();
        send(1'b1);
        send(1'b1);
        send(1'b0);
        txv <= 1'b0;
        repeat (10) @(posedge clk);
        chk(na, 32'h2);
        chk(nb, 32'h2);
        chk(32'(tled), 32'h0);
        repeat (20) @(posedge clk);
        chk(32'(tled), 32'h1);
        wb(1'b1, 4'h0, 32'h1);
        chk(32'(txdis), 32'h1);
        send(1'b1);
        txv <= 1'b0;
        repeat (10) @(posedge clk);
        chk(na, 32'h2);
        chk(32'(tled), 32'h1);
        wb(1'b1, 4'h0, 32'h0);
    endtask : t_tx
    task automatic t_rx();
        // Pulses land one late, then two early, then two late against the eight-cycle slots; slot three is empty.
        int g[4] = '{1, 9, 6, 18};
        rxq.delete();
        foreach (g[i]) begin
            repeat (g[i] - 1) @(posedge clk);
            fire <= 1'b1;
            @(posedge clk);
            fire <= 1'b0;
        end
        repeat (200) @(posedge clk);
        chk(32'({rxq[0], rxq[1], rxq[2], rxq[3], rxq[4]}), 32'h1d);
        chk(32'(rxa), 32'h0);
        rd(4'h4, 32'h2);
        wb(1'b1, 4'h4, 32'h2);
        rd(4'h4, 32'h0);
    endtask : t_rx
    task automatic t_evt();
        evt(2'b01, 1'b1);
        rd(4'h4, 32'h1);
        rd(4'hc, 32'h11);
        chk(32'(irq), 32'h0);
        wb(1'b1, 4'h8, 32'h7);
        chk(32'(irq), 32'h1);
        evt(2'b01, 1'b0);
        wb(1'b0, 4'hc, 32'h0);
        chk(q & 32'h1, 32'h0);
        wb(1'b1, 4'h4, 32'h1);
        chk(32'(irq), 32'h0);
        evt(2'b10, 1'b1);
        rd(4'h4, 32'h0);
        evt(2'b10, 1'b0);
        rd(4'h4, 32'h4);
        chk(32'(irq), 32'h1);
        repeat (45) @(posedge clk);
        chk(32'(hled), 32'h1);
        evt(2'b00, 1'b0);
        chk(32'(hled), 32'h0);
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk(32'(irq), 32'h0);
        chk(32'(hled), 32'h1);
    endtask : t_evt
    task automatic tally_and_finish();
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : tally_and_finish
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_regs();
        t_tx();
        t_rx();
        t_evt();
        tally_and_finish();
    end
endmodule : dlc_line_codec_test

// ==== sim/dlc_media_model.sv ====
module dlc_media_model (
    input wire logic clk_i,
    input wire logic fire_i,
    input wire logic tx_pulse_a_n_i,
    input wire logic tx_pulse_b_n_i,
    output logic line_o,
    output int n_a,
    output int n_b
);
    timeunit 1ns;
    timeprecision 1ns;
    int left = 0;
    // The coupled receive line rests low between pulses.
    assign line_o = (left != 0);
    always @(posedge clk_i) begin
        left <= fire_i ? 2 : (left > 0 ? left - 1 : 0);
        if (tx_pulse_a_n_i === 1'b0) n_a <= n_a + 1;
        if (tx_pulse_b_n_i === 1'b0) n_b <= n_b + 1;
    end
endmodule : dlc_media_model
